// [inc/msf_map.svh]
`ifndef MSF_MAP_SVH
`define MSF_MAP_SVH
`define MSF_OFS_IO_CTRL 7'h22
`define MSF_OFS_MISC 7'h23
`define MSF_OFS_SELFTEST 7'h24
`define MSF_OFS_EVT_SRC 7'h26
`define MSF_OFS_STATUS 7'h27
`define MSF_OFS_OUT_X 7'h28
`define MSF_OFS_OUT_Y 7'h2a
`define MSF_OFS_OUT_Z 7'h2c
`define MSF_OFS_BUF_CTRL 7'h2e
`define MSF_OFS_BUF_STAT 7'h2f
`define MSF_BIT_HOLD 6
`define MSF_BIT_SLEEP 6
`define MSF_BIT_TEMP 4
`define MSF_BIT_TIMER 3
`define MSF_BIT_TWO_OFF 2
`define MSF_BIT_BUF_ON 1
`define MSF_BIT_LIMIT 0
`define MSF_BIT_RATE_ST 2
`define MSF_BIT_ACCEL_ST 0
`define MSF_MASK_IO_CTRL 8'h40
`define MSF_MASK_MISC 8'h5f
`define MSF_MASK_SELFTEST 8'h05
`define MSF_RST_IO_CTRL 8'h00
`define MSF_RST_MISC 8'h00
`define MSF_RST_SELFTEST 8'h00
`define MSF_RST_BUF_CTRL 8'h00
`define MSF_BUF_DEPTH 32
`define MSF_CLK_MHZ 25
`define MSF_AVAIL_NS 1000
`define MSF_AVAIL_CYC ((`MSF_AVAIL_NS * `MSF_CLK_MHZ) / 1000)
`endif

// [inc/msf_pkg.sv]
package msf_pkg;
  typedef enum logic [2:0] {
    MSF_MODE_BYPASS = 3'h0,
    MSF_MODE_FIFO = 3'h1,
    MSF_MODE_RSVD = 3'h2,
    MSF_MODE_CONT_FIFO = 3'h3,
    MSF_MODE_BYP_CONT = 3'h4,
    MSF_MODE_CONT = 3'h6
  } msf_mode_t;
  typedef enum logic [2:0] {
    MSF_ST_OFF = 3'h0,
    MSF_ST_PRE = 3'h1,
    MSF_ST_LIVE = 3'h3,
    MSF_ST_RING = 3'h2,
    MSF_ST_FILL = 3'h6
  } msf_state_t;
  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] z;
    logic [15:0] y;
    logic [15:0] x;
  } msf_sample_t;
endpackage : msf_pkg

// [inc/msf_stream_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface msf_stream_if;
  import msf_pkg::*;
  logic valid;
  logic ready;
  msf_sample_t data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface : msf_stream_if
`default_nettype wire

// [hdl/msf_skid.sv]
`timescale 1ns/1ps
`default_nettype none
module msf_skid
  import msf_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  msf_stream_if.snk in_if,
  msf_stream_if.src out_if
);
  msf_sample_t a_q;
  msf_sample_t b_q;
  logic a_valid_q;
  logic b_valid_q;
  logic push;
  logic pop;

  // second slot catches the word already in flight when the sink stalls
  assign in_if.ready = ~b_valid_q;
  assign out_if.valid = a_valid_q;
  assign out_if.data = a_q;
  assign push = in_if.valid & ~b_valid_q;
  assign pop = a_valid_q & out_if.ready;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      a_valid_q <= 1'b0;
      b_valid_q <= 1'b0;
      a_q <= '0;
      b_q <= '0;
    end else if (pop) begin
      if (b_valid_q) begin
        a_q <= b_q;
        b_valid_q <= 1'b0;
      end else begin
        a_valid_q <= push;
        a_q <= in_if.data;
      end
    end else if (push) begin
      if (!a_valid_q) begin
        a_valid_q <= 1'b1;
        a_q <= in_if.data;
      end else begin
        b_valid_q <= 1'b1;
        b_q <= in_if.data;
      end
    end
  end

  skid_order_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    b_valid_q |-> a_valid_q) else $error("spare slot used while head empty");
  skid_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    a_valid_q && !out_if.ready |=> a_valid_q && $stable(a_q))
    else $error("stalled word changed");
endmodule : msf_skid
`default_nettype wire

// [hdl/msf_regs.sv]
// Contract
// - sleep bit puts gyroscope asleep
// - temp flag stores temperature in buffer
// - availability timer runs only when enabled
// - two-wire off leaves only four-wire port
// - buffer works only when enabled
// - depth limit caps buffer at threshold
// - self-test enables for rate and accel
// - event source flags plus any-event bit
// - status shows generator event outputs
// - reload flag high during reload
// - new-sample flags set on fresh data
// - axis words little endian at 28h-2Dh
// - mode field upper, threshold lower bits
// - mode 000 bypass, 010 reserved
// - mode 001 stops when full
// - mode 011 continuous, then stop-when-full
// - mode 100 bypass, then continuous
// - mode 110 overwrites oldest when full
// - level flag when filling reaches threshold
// - overrun flag when full and overwritten
// - six-bit unread count, 32 means full
// - hold mode freezes pair until read
`timescale 1ns/1ps
`default_nettype none
`include "msf_map.svh"
module msf_regs
  import msf_pkg::*;
#(
  parameter int DEPTH = `MSF_BUF_DEPTH,
  parameter int AVAIL_CYC = `MSF_AVAIL_CYC
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic spi_sck_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_n_o,
  input wire logic sample_valid_i,
  output logic sample_ready_o,
  input wire logic [15:0] accel_x_i,
  input wire logic [15:0] accel_y_i,
  input wire logic [15:0] accel_z_i,
  input wire logic [15:0] temp_i,
  input wire logic temp_strobe_i,
  input wire logic rate_strobe_i,
  input wire logic trigger_i,
  input wire logic [5:0] accel_event_i,
  input wire logic accel_event_out_i,
  input wire logic rate_event_out_i,
  input wire logic idle_event_i,
  input wire logic reload_running_i,
  output logic rate_sleep_o,
  output logic temp_into_buffer_o,
  output logic avail_tick_o,
  output logic two_wire_enable_o,
  output logic rate_selftest_o,
  output logic accel_selftest_o,
  output logic [15:0] buffer_temp_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [7:0] io_ctrl_q;
  logic [7:0] misc_q;
  logic [7:0] selftest_q;
  logic [7:0] buf_ctrl_q;
  logic [5:0] evt_q;
  logic [2:0] gen_evt_q;
  logic reload_q;
  logic temp_new_q;
  logic rate_new_q;
  logic accel_new_q;
  logic [2:0][15:0] outw_q;
  logic [2:0] pend_q;
  msf_sample_t mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  logic ovr_q;
  msf_state_t st_q;
  logic [2:0] mode_seen_q;
  logic [15:0] timer_q;
  logic [15:0] temp_head_q;

  // serial port: three flops on clock, two on select and data, the first feeds only the second
  logic [2:0] sck_s;
  logic [1:0] cs_s;
  logic [1:0] mosi_s;
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic [2:0] bit_q;
  logic cmd_done_q;
  logic rd_q;
  logic [6:0] addr_q;
  logic drive_q;

  logic sck_rise;
  logic sck_fall;
  logic cs_act;
  logic [7:0] rx_next;
  logic byte_done;
  logic wr_stb;
  logic rd_stb;
  logic [6:0] rd_addr;
  logic [7:0] rd_byte;
  logic [7:0] wdata;

  assign sck_rise = sck_s[1] & ~sck_s[2];
  assign sck_fall = ~sck_s[1] & sck_s[2];
  assign cs_act = ~cs_s[1];
  assign rx_next = {rx_q[6:0], mosi_s[1]};
  assign byte_done = cs_act & sck_rise & (bit_q == 3'h7);
  assign wr_stb = byte_done & cmd_done_q & ~rd_q;
  assign rd_stb = byte_done & (cmd_done_q ? rd_q : rx_next[7]);
  assign rd_addr = cmd_done_q ? addr_q + 7'h01 : rx_next[6:0];
  assign wdata = rx_next;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sck_s <= 3'h7;
      cs_s <= 2'h3;
      mosi_s <= 2'h0;
    end else begin
      sck_s <= {sck_s[1:0], spi_sck_i};
      cs_s <= {cs_s[0], spi_cs_n_i};
      mosi_s <= {mosi_s[0], spi_mosi_i};
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_q <= 8'h00;
      bit_q <= 3'h0;
      cmd_done_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 7'h00;
    end else if (!cs_act) begin
      bit_q <= 3'h0;
      cmd_done_q <= 1'b0;
      rd_q <= 1'b0;
    end else if (sck_rise) begin
      rx_q <= rx_next;
      bit_q <= bit_q + 3'h1;
      if (byte_done && !cmd_done_q) begin
        cmd_done_q <= 1'b1;
        rd_q <= rx_next[7];
        addr_q <= rx_next[6:0];
      end else if (byte_done) begin
        addr_q <= addr_q + 7'h01;
      end
    end
  end

  // miso changes on falling clock, first bit ready before first rise
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_q <= 8'h00;
      drive_q <= 1'b0;
    end else begin
      drive_q <= cs_act & (rd_q | rd_stb);
      if (rd_stb) begin
        tx_q <= rd_byte;
      end else if (cs_act && sck_fall && bit_q != 3'h0) begin
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end
  assign spi_miso_o = tx_q[7];
  assign spi_miso_oe_n_o = ~drive_q;

  // sample path and buffer control
  msf_stream_if sk_in ();
  msf_stream_if sk_out ();
  msf_skid u_skid (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .in_if(sk_in),
    .out_if(sk_out)
  );

  logic buffering;
  logic ring_like;
  logic [CW-1:0] cap;
  logic full;
  logic take;
  logic push;
  logic over;
  logic pop_rd;
  logic pop;
  logic zhi_rd;
  logic [4:0] level;
  msf_sample_t head;
  logic [2:0][15:0] view;

  assign sk_in.valid = sample_valid_i;
  // temperature rides along only when enabled
  assign sk_in.data = '{temp: misc_q[`MSF_BIT_TEMP] ? temp_i : 16'h0000,
                        z: accel_z_i, y: accel_y_i, x: accel_x_i};
  assign sample_ready_o = sk_in.ready;

  assign level = buf_ctrl_q[4:0];
  assign buffering = (st_q == MSF_ST_FILL) | (st_q == MSF_ST_LIVE) | (st_q == MSF_ST_RING);
  assign ring_like = (st_q == MSF_ST_LIVE) | (st_q == MSF_ST_RING);
  // threshold caps depth; a zero threshold then stores nothing
  assign cap = misc_q[`MSF_BIT_LIMIT] ? CW'(level) : CW'(DEPTH);
  assign full = count_q >= cap;
  // stop-when-full stalls the skid, so the source sees back-pressure
  assign take = ~((st_q == MSF_ST_FILL) & full);
  assign sk_out.ready = take;
  assign push = sk_out.valid & take & buffering & (cap != '0);
  // a full ring drops its oldest entry
  assign over = push & full & ring_like;
  assign zhi_rd = rd_stb & (rd_addr == `MSF_OFS_OUT_Z + 7'h01);
  assign pop_rd = zhi_rd & buffering & (count_q != '0);
  assign pop = over | pop_rd;
  assign head = mem_q[rd_ptr_q];
  // reads come from the buffer head while buffering
  assign view = buffering ? {head.z, head.y, head.x} : outw_q;

  // buffer modes only run while the buffer is enabled
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q <= MSF_ST_OFF;
      mode_seen_q <= 3'h0;
    end else begin
      mode_seen_q <= buf_ctrl_q[7:5];
      if (!misc_q[`MSF_BIT_BUF_ON] || buf_ctrl_q[7:5] != mode_seen_q) begin
        st_q <= MSF_ST_OFF;
      end else begin
        unique case (st_q)
          MSF_ST_OFF: begin
            // bypass and reserved codes keep the buffer off
            if (buf_ctrl_q[7:5] == MSF_MODE_FIFO) st_q <= MSF_ST_FILL;
            else if (buf_ctrl_q[7:5] == MSF_MODE_CONT_FIFO) st_q <= MSF_ST_LIVE;
            else if (buf_ctrl_q[7:5] == MSF_MODE_BYP_CONT) st_q <= MSF_ST_PRE;
            else if (buf_ctrl_q[7:5] == MSF_MODE_CONT) st_q <= MSF_ST_RING;
          end
          // bypass until trigger drops, then continuous
          MSF_ST_PRE: if (!trigger_i) st_q <= MSF_ST_RING;
          MSF_ST_LIVE: if (!trigger_i) st_q <= MSF_ST_FILL;
          MSF_ST_RING: st_q <= MSF_ST_RING;
          MSF_ST_FILL: st_q <= MSF_ST_FILL;
          default: st_q <= MSF_ST_OFF;
        endcase
      end
    end
  end

  // no reset on storage; count bounds what is valid
  always_ff @(posedge clk_i) begin
    if (push) mem_q[wr_ptr_q] <= sk_out.data;
  end

  // one up per store, one down per Z high-byte read or overwrite
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else if (!buffering) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop) rd_ptr_q <= rd_ptr_q + 1'b1;
      count_q <= count_q + CW'(push) - CW'(pop);
    end
  end

  // set on overwrite, kept until a read drops below full
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) ovr_q <= 1'b0;
    else if (!buffering) ovr_q <= 1'b0;
    else if (over) ovr_q <= 1'b1;
    else if (pop_rd) ovr_q <= 1'b0;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) temp_head_q <= 16'h0000;
    else temp_head_q <= head.temp;
  end
  assign buffer_temp_o = temp_head_q;

  // per-word output registers and read-pair hold
  genvar gi;
  for (gi = 0; gi < 3; gi++) begin : g_word
    localparam logic [6:0] LO = `MSF_OFS_OUT_X + 7'(2 * gi);
    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        outw_q[gi] <= 16'h0000;
        pend_q[gi] <= 1'b0;
      end else begin
        // a half-read pair is frozen until its high byte goes
        if (rd_stb && rd_addr == LO) pend_q[gi] <= 1'b1;
        else if (rd_stb && rd_addr == LO + 7'h01) pend_q[gi] <= 1'b0;
        if (sk_out.valid && !buffering && !(io_ctrl_q[`MSF_BIT_HOLD] && pend_q[gi])) begin
          outw_q[gi] <= sk_out.data[16*gi +: 16];
        end
      end
    end
  end

  // sticky event flags, cleared on read, a new event wins
  // generator outputs and reload flag follow their sources
  // temp and rate new-sample flags stick until status is read, accel flag until Z high byte is read
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      evt_q <= 6'h00;
      gen_evt_q <= 3'h0;
      reload_q <= 1'b0;
      temp_new_q <= 1'b0;
      rate_new_q <= 1'b0;
      accel_new_q <= 1'b0;
    end else begin
      evt_q <= (evt_q & ~{6{rd_stb && rd_addr == `MSF_OFS_EVT_SRC}}) | accel_event_i;
      gen_evt_q <= {accel_event_out_i, rate_event_out_i, idle_event_i};
      reload_q <= reload_running_i;
      temp_new_q <= (temp_new_q & ~(rd_stb && rd_addr == `MSF_OFS_STATUS)) | temp_strobe_i;
      rate_new_q <= (rate_new_q & ~(rd_stb && rd_addr == `MSF_OFS_STATUS)) | rate_strobe_i;
      accel_new_q <= (accel_new_q & ~zhi_rd) | (sk_out.valid & take);
    end
  end

  // reserved bits are dropped on write and read as zero
  // mode and threshold stored whole in one byte
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      io_ctrl_q <= `MSF_RST_IO_CTRL;
      misc_q <= `MSF_RST_MISC;
      selftest_q <= `MSF_RST_SELFTEST;
      buf_ctrl_q <= `MSF_RST_BUF_CTRL;
    end else if (wr_stb) begin
      if (addr_q == `MSF_OFS_IO_CTRL) io_ctrl_q <= wdata & `MSF_MASK_IO_CTRL;
      if (addr_q == `MSF_OFS_MISC) misc_q <= wdata & `MSF_MASK_MISC;
      if (addr_q == `MSF_OFS_SELFTEST) selftest_q <= wdata & `MSF_MASK_SELFTEST;
      if (addr_q == `MSF_OFS_BUF_CTRL) buf_ctrl_q <= wdata;
    end
  end

  // an empty buffer never reaches the level; six-bit count
  always_comb begin
    rd_byte = 8'h00;
    unique case (rd_addr)
      `MSF_OFS_IO_CTRL: rd_byte = io_ctrl_q;
      `MSF_OFS_MISC: rd_byte = misc_q;
      `MSF_OFS_SELFTEST: rd_byte = selftest_q;
      `MSF_OFS_EVT_SRC: rd_byte = {1'b0, |evt_q, evt_q};
      `MSF_OFS_STATUS: rd_byte = {1'b0, gen_evt_q, reload_q, temp_new_q, rate_new_q,
                                  accel_new_q};
      `MSF_OFS_OUT_X: rd_byte = view[0][7:0];
      `MSF_OFS_OUT_X + 7'h01: rd_byte = view[0][15:8];
      `MSF_OFS_OUT_Y: rd_byte = view[1][7:0];
      `MSF_OFS_OUT_Y + 7'h01: rd_byte = view[1][15:8];
      `MSF_OFS_OUT_Z: rd_byte = view[2][7:0];
      `MSF_OFS_OUT_Z + 7'h01: rd_byte = view[2][15:8];
      `MSF_OFS_BUF_CTRL: rd_byte = buf_ctrl_q;
      `MSF_OFS_BUF_STAT: rd_byte = {count_q != '0 && count_q >= CW'(level), ovr_q, 6'(count_q)};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      timer_q <= 16'h0000;
      avail_tick_o <= 1'b0;
    end else if (!misc_q[`MSF_BIT_TIMER]) begin
      timer_q <= 16'h0000;
      avail_tick_o <= 1'b0;
    end else begin
      avail_tick_o <= timer_q == 16'(AVAIL_CYC - 1);
      timer_q <= (timer_q == 16'(AVAIL_CYC - 1)) ? 16'h0000 : timer_q + 16'h0001;
    end
  end

  // sleep; two-wire port enable; self-test enables
  assign rate_sleep_o = misc_q[`MSF_BIT_SLEEP];
  assign temp_into_buffer_o = misc_q[`MSF_BIT_TEMP];
  assign two_wire_enable_o = ~misc_q[`MSF_BIT_TWO_OFF];
  assign rate_selftest_o = selftest_q[`MSF_BIT_RATE_ST];
  assign accel_selftest_o = selftest_q[`MSF_BIT_ACCEL_ST];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sleep_write_a: assert property (
    wr_stb && addr_q == `MSF_OFS_MISC |=> rate_sleep_o == $past(wdata[`MSF_BIT_SLEEP]))
    else $error("sleep output not following write");
  reserved_zero_a: assert property (
    (selftest_q & ~`MSF_MASK_SELFTEST) == 8'h00) else $error("reserved self-test bit set");
  fill_stop_a: assert property (
    st_q == MSF_ST_FILL && full |=> count_q <= $past(count_q))
    else $error("store while full in stop mode");
  overrun_set_a: assert property (
    over |=> ovr_q && count_q == $past(count_q)) else $error("overwrite not flagged");
  count_bound_a: assert property (
    count_q <= CW'(DEPTH)) else $error("unread count above depth");
  off_flush_a: assert property (
    !misc_q[`MSF_BIT_BUF_ON] |=> st_q == MSF_ST_OFF ##1 count_q == '0)
    else $error("buffer not flushed when disabled");
  level_read_a: assert property (
    rd_stb && rd_addr == `MSF_OFS_BUF_STAT |=>
      tx_q[7] == ($past(count_q) != '0 && $past(count_q) >= $past(CW'(level))))
    else $error("level flag wrong on read");
  hold_pair_a: assert property (
    io_ctrl_q[`MSF_BIT_HOLD] && pend_q[0] |=> $stable(outw_q[0]))
    else $error("held pair updated");
  event_keep_a: assert property (
    evt_q[0] && !(rd_stb && rd_addr == `MSF_OFS_EVT_SRC) |=> evt_q[0])
    else $error("event flag lost without read");

  ring_cov: cover property (st_q == MSF_ST_RING && over);
  switch_cov: cover property (st_q == MSF_ST_LIVE ##1 st_q == MSF_ST_FILL);
  stall_cov: cover property (sample_valid_i && !sample_ready_o);
endmodule : msf_regs
`default_nettype wire

// [verif/msf_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module msf_host_model (
  input wire logic clk_i,
  output logic sck_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  initial begin
    sck_o = 1'b1;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // two bytes per frame, clock idle high, msb first; callers also write nonzero bytes to reserved and read-only addresses
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] wd,
                      output logic [7:0] rdata);
    logic [15:0] sh;
    sh = {rd, a, wd};
    rdata = 8'h00;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int i = 15; i >= 0; i--) begin
      sck_o <= 1'b0;
      mosi_o <= sh[i];
      repeat (4) @(posedge clk_i);
      sck_o <= 1'b1;
      if (i < 8) rdata[i] = miso_i;
      repeat (4) @(posedge clk_i);
    end
    cs_n_o <= 1'b1;
    // released line must not keep a stale level
    mosi_o <= ~mosi_o;
    repeat (8) @(posedge clk_i);
  endtask : xfer
endmodule : msf_host_model
`default_nettype wire

// [verif/msf_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module msf_regs_tb;
  import msf_pkg::*;
  typedef struct packed {logic w; logic [6:0] a; logic [7:0] d; logic [7:0] e;} msf_tb_row_t;
  localparam msf_tb_row_t ROWS [0:18] = '{
    {1'b0, 7'h22, 8'h00, 8'h00}, {1'b0, 7'h23, 8'h00, 8'h00}, {1'b0, 7'h24, 8'h00, 8'h00},
    {1'b0, 7'h26, 8'h00, 8'h00}, {1'b0, 7'h27, 8'h00, 8'h00}, {1'b0, 7'h2e, 8'h00, 8'h00},
    {1'b0, 7'h2f, 8'h00, 8'h00}, {1'b0, 7'h25, 8'h00, 8'h00}, {1'b1, 7'h23, 8'h5f, 8'h5f},
    {1'b1, 7'h24, 8'h05, 8'h05}, {1'b1, 7'h2e, 8'h3f, 8'h3f}, {1'b1, 7'h27, 8'hff, 8'h00},
    {1'b1, 7'h25, 8'haa, 8'h00}, {1'b1, 7'h30, 8'h55, 8'h00}, {1'b1, 7'h22, 8'h40, 8'h40},
    {1'b1, 7'h22, 8'h00, 8'h00}, {1'b1, 7'h2e, 8'h00, 8'h00}, {1'b1, 7'h23, 8'h00, 8'h00},
    {1'b1, 7'h24, 8'h00, 8'h00}};
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic sck, cs_n, mosi, miso, miso_oe_n, miso_w, ready, sleep, temp_o, tick, two_en, rst_o, ast_o;
  logic valid = 1'b0, trig = 1'b1, t_stb = 1'b0, r_stb = 1'b0;
  logic ev_a = 1'b0, ev_r = 1'b0, ev_i = 1'b0, reload = 1'b0;
  logic [5:0] ev = 6'h00;
  logic [15:0] btemp;
  logic [7:0] rd;
  logic [6:0] outs;
  msf_sample_t smp = '0;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int ticks = 0;
  always #20 clk_i = ~clk_i;
  // a released output is seen inverted, never as a stale level
  assign miso_w = miso_oe_n ? ~miso : miso;
  assign outs = {sleep, temp_o, two_en, rst_o, ast_o, miso_oe_n, tick};
  msf_regs #(.DEPTH(32), .AVAIL_CYC(4)) i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .spi_sck_i(sck), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso),
    .spi_miso_oe_n_o(miso_oe_n), .sample_valid_i(valid), .sample_ready_o(ready),
    .accel_x_i(smp.x), .accel_y_i(smp.y), .accel_z_i(smp.z), .temp_i(smp.temp),
    .temp_strobe_i(t_stb), .rate_strobe_i(r_stb), .trigger_i(trig), .accel_event_i(ev),
    .accel_event_out_i(ev_a), .rate_event_out_i(ev_r), .idle_event_i(ev_i),
    .reload_running_i(reload), .rate_sleep_o(sleep), .temp_into_buffer_o(temp_o),
    .avail_tick_o(tick), .two_wire_enable_o(two_en), .rate_selftest_o(rst_o),
    .accel_selftest_o(ast_o), .buffer_temp_o(btemp));
  msf_host_model i_host (.clk_i(clk_i), .sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi),
    .miso_i(miso_w));
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : check
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_host.xfer(1'b0, a, d, rd);
  endtask : wr
  task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
    i_host.xfer(1'b1, a, 8'h00, rd);
    check($sformatf("reg %h", a), {8'h00, e}, {8'h00, rd});
  endtask : rdchk
  // holds valid up between back-to-back words; caller lowers it
  task automatic push(input logic [15:0] x);
    int w;
    w = 0;
    smp <= '{temp: x ^ 16'h5a00, z: ~x, y: x + 16'h0100, x: x};
    valid <= 1'b1;
    @(posedge clk_i);
    while (ready !== 1'b1 && w < 50) begin
      @(posedge clk_i);
      w++;
    end
    if (w >= 50) check("sample ready", 16'h0001, 16'h0000);
  endtask : push
  task automatic fill(input int first, input int n);
    for (int k = first; k < first + n; k++) push(16'(k));
    valid <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : fill
  always @(posedge clk_i) begin
    cycles++;
    if (tick === 1'b1) ticks++;
    if (cycles == 60000) begin
      check("run length", 16'h0000, 16'h0001);
      summarize();
    end
  end
  initial begin
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    check("outputs at reset", 16'h0012, {9'h000, outs});
    foreach (ROWS[i]) begin
      if (ROWS[i].w) wr(ROWS[i].a, ROWS[i].d);
      rdchk(ROWS[i].a, ROWS[i].e);
    end
    $display("test register table done");
    wr(7'h23, 8'h54);
    wr(7'h24, 8'h05);
    check("control outputs", 16'h006e, {9'h000, outs});
    wr(7'h23, 8'h08);
    ticks = 0;
    repeat (40) @(posedge clk_i);
    check("timer running", 16'h0001, {15'h0000, ticks > 0});
    wr(7'h23, 8'h00);
    wr(7'h24, 8'h00);
    ticks = 0;
    repeat (40) @(posedge clk_i);
    check("timer stopped", 16'h0000, 16'(ticks));
    $display("test control bits done");
    ev <= 6'h21;
    ev_a <= 1'b1;
    ev_i <= 1'b1;
    reload <= 1'b1;
    t_stb <= 1'b1;
    r_stb <= 1'b1;
    @(posedge clk_i);
    ev <= 6'h00;
    t_stb <= 1'b0;
    r_stb <= 1'b0;
    fill(16'h1234, 1);
    rdchk(7'h27, 8'h5f);
    rdchk(7'h26, 8'h61);
    rdchk(7'h26, 8'h00);
    rdchk(7'h27, 8'h59);
    ev_a <= 1'b0;
    ev_i <= 1'b0;
    reload <= 1'b0;
    foreach (ROWS[i]) if (i < 6) rdchk(7'h28 + 7'(i), 8'({16'hedcb, 16'h1334, 16'h1234} >> (8 * i)));
    rdchk(7'h27, 8'h00);
    wr(7'h22, 8'h40);
    rdchk(7'h27, 8'h00);
    fill(16'h0777, 1);
    rdchk(7'h28, 8'h34);
    rdchk(7'h2a, 8'h77);
    wr(7'h22, 8'h00);
    fill(16'h0777, 1);
    rdchk(7'h28, 8'h77);
    $display("test status and outputs done");
    wr(7'h23, 8'h12);
    wr(7'h2e, 8'h24);
    fill(0, 33);
    rdchk(7'h2f, 8'ha0);
    for (int k = 0; k < 32; k++) begin
      rdchk(7'h28, 8'(k));
      check("buffer temp", 16'h5a00 ^ 16'(k), btemp);
      rdchk(7'h2d, 8'hff);
      if (k == 28) rdchk(7'h2f, 8'h84);
      if (k == 29) rdchk(7'h2f, 8'h03);
    end
    rdchk(7'h2f, 8'h01);
    rdchk(7'h28, 8'h20);
    rdchk(7'h2d, 8'hff);
    rdchk(7'h2f, 8'h00);
    $display("test stop when full done");
    wr(7'h2e, 8'hc4);
    fill(0, 34);
    rdchk(7'h2f, 8'he0);
    rdchk(7'h28, 8'h02);
    rdchk(7'h2d, 8'hff);
    rdchk(7'h2f, 8'h9f);
    $display("test overwrite done");
    wr(7'h23, 8'h03);
    wr(7'h2e, 8'h24);
    fill(0, 6);
    rdchk(7'h2f, 8'h84);
    wr(7'h2e, 8'h04);
    fill(16'h40, 2);
    rdchk(7'h2f, 8'h00);
    rdchk(7'h28, 8'h41);
    wr(7'h23, 8'h02);
    wr(7'h2e, 8'h84);
    fill(0, 3);
    rdchk(7'h2f, 8'h00);
    trig <= 1'b0;
    fill(0, 3);
    rdchk(7'h2f, 8'h03);
    trig <= 1'b1;
    wr(7'h2e, 8'h64);
    fill(0, 34);
    trig <= 1'b0;
    rdchk(7'h2f, 8'he0);
    check("buffer temp", 16'h0000, btemp);
    rdchk(7'h2d, 8'hff);
    fill(16'h50, 2);
    rdchk(7'h2f, 8'ha0);
    wr(7'h23, 8'h00);
    rdchk(7'h2f, 8'h00);
    $display("test buffer modes done");
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rdchk(7'h2e, 8'h00);
    rdchk(7'h2f, 8'h00);
    $display("test second reset done");
    summarize();
  end
endmodule : msf_regs_tb
`default_nettype wire
